// ### core/sync_burst_sram_pkg.sv
// Shared constants, control carrier and helpers for the burst memory access control
package sync_burst_sram_pkg;

	// Array and bus shape
	localparam int ADDR_W = 17;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int BURST_W = 2;

	// Burst order strap levels and counter figures
	localparam logic ORDER_INTERLEAVED = 1'b1;
	localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
	localparam logic [BURST_W-1:0] BURST_LAST = 2'h3;

	// Reset levels of the drive enable synchronisers and the drivers
	localparam logic ASYNC_IDLE_N = 1'b1;
	localparam logic DRIVE_OFF_N = 1'b1;

	// Synchronous bus controls, all sampled on the rising edge
	typedef struct packed {
		logic proc_addr_strobe_n;
		logic ctrl_addr_strobe_n;
		logic burst_advance_n;
		logic global_write_n;
		logic byte_write_gate_n;
		logic [LANES-1:0] byte_lane_select_n;
		logic pipelined_chip_select_n;
		logic depth_select_high;
		logic depth_select_low_n;
	} bus_ctl_t;

	// Low address bits of a beat; both orders wrap inside four words
	function automatic logic [BURST_W-1:0] burst_lo(input logic linear,
			input logic [BURST_W-1:0] start, input logic [BURST_W-1:0] beat);
		burst_lo = linear ? BURST_W'(start + beat) : (start ^ beat);
	endfunction

	// Lanes that the write controls select; global write overrides the gate
	function automatic logic [LANES-1:0] write_lanes(input bus_ctl_t c);
		if (!c.global_write_n) begin
			write_lanes = '1;
		end else if (!c.byte_write_gate_n) begin
			write_lanes = ~c.byte_lane_select_n;
		end else begin
			write_lanes = '0;
		end
	endfunction

endpackage

// ### core/sram_word_mem.sv
// Word array with per-lane writes and a registered read port
`timescale 1ns/1ps
module sram_word_mem
	import sync_burst_sram_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W,
	parameter int NL = LANES
) (
	// Clock
	input wire logic clk_sys,
	// Access
	input wire logic wr_en,
	input wire logic [NL-1:0] lane_en,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);

	localparam int LW = DW / NL;

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Unselected lanes keep their contents; read data always comes out of a register
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < NL; i++) begin
			if (wr_en && lane_en[i]) begin
				mem[addr][i*LW +: LW] <= wdata[i*LW +: LW];
			end
		end
		rdata <= mem[addr];
	end

endmodule

// ### core/sync_burst_sram_access_ctrl.sv
// Synchronous access control of a pipelined double-cycle-deselect burst memory
//
// Summary of operation
// - Processor strobe with chip selected loads address; write and advance inputs ignored.
// - Processor-strobe write takes two cycles; global write low writes all bytes.
// - Otherwise only lanes selected under a low byte write gate are written.
// - Data lines go high impedance whenever a write cycle is detected.
// - Controller strobe, processor strobe high, selected and write decode start a write.
// - Controller-strobe write completes in one cycle; address loaded, advance ignored.
// - Two-bit wrapping burst counter from low address bits, order set by strap.
// - Advance low at a clock rise steps to the next burst address.
// - No strobe and advance high: suspend, access current address again.
// - Strap high gives interleaved order: start bits exclusive-or beat number.
// - Strap low gives linear order: start plus beat modulo four.
// - Sleep request enters low power within two cycles, leaves within two; outputs off.
// - An access pending at sleep entry is dropped as invalid.
// - Deselect cycle on pipelined select high with controller strobe, or depth miss.
// - Processor strobe while selected begins a read burst whatever the write inputs.
// - Controller strobe alone begins a burst: write if decode active, else read.
// - No strobe and advance low: continue burst at next counter address.
// - Write decode: global write low, or gate low with any lane selected.
// - Output drive enable is masked internally during write cycles.
// - After a deselect the outputs stay driven until the following clock rise.
// - Read data passes an output register, driven after the next clock rise.
`timescale 1ns/1ps
module sync_burst_sram_access_ctrl
	import sync_burst_sram_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Synchronous bus controls and address
	input wire bus_ctl_t ctl,
	input wire logic [AW-1:0] addr,
	// Strap and asynchronous inputs
	input wire logic burst_order_sel,
	input wire logic output_drive_enable_n,
	input wire logic sleep_request,
	// Shared data lines, split into three signals
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe_n,
	// Status
	output logic sleep_active
);

	typedef struct packed {
		logic oe_s1;
		logic oe_s2;
		logic zz_s1;
		logic zz_s2;
		logic mode_linear;
		logic active;
		logic [AW-1:0] base;
		logic [BURST_W-1:0] beat;
		logic rd_stage;
		logic out_en_n;
		logic [DATA_W-1:0] dq_out;
	} state_t;

	localparam state_t ST_RESET = '{
		oe_s1: ASYNC_IDLE_N,
		oe_s2: ASYNC_IDLE_N,
		out_en_n: DRIVE_OFF_N,
		default: '0
	};

	state_t st;
	state_t next_st;

	logic chip_sel;
	logic depth_ok;
	logic proc_ok;
	logic deselect;
	logic start_proc;
	logic start_ctrl;
	logic cont_cycle;
	logic [LANES-1:0] lanes;
	logic wr_dec;
	logic mem_we;
	logic [LANES-1:0] mem_lanes;
	logic [AW-1:0] mem_addr;
	logic [DATA_W-1:0] mem_rdata;
	logic acc_rd;
	logic acc_wr;
	logic [BURST_W-1:0] step_beat;

	// Cycle decode on the sampled controls
	assign depth_ok = ctl.depth_select_high & ~ctl.depth_select_low_n;
	assign chip_sel = ~ctl.pipelined_chip_select_n & depth_ok;
	assign proc_ok = ~ctl.proc_addr_strobe_n & ~ctl.pipelined_chip_select_n;
	assign deselect = (ctl.pipelined_chip_select_n & ~ctl.ctrl_addr_strobe_n)
		| (~ctl.pipelined_chip_select_n & ~depth_ok
		& (~ctl.proc_addr_strobe_n | ~ctl.ctrl_addr_strobe_n));
	assign start_proc = ~st.zz_s2 & ~deselect & proc_ok & chip_sel;
	assign start_ctrl = ~st.zz_s2 & ~deselect & ~proc_ok
		& ~ctl.ctrl_addr_strobe_n & chip_sel;
	// A blocked processor strobe counts as idle, so continue and suspend still apply
	assign cont_cycle = ~st.zz_s2 & ~deselect & ~proc_ok
		& ctl.ctrl_addr_strobe_n & st.active;
	assign lanes = write_lanes(ctl);
	assign wr_dec = |lanes;
	assign step_beat = ctl.burst_advance_n ? st.beat : BURST_W'(st.beat + BURST_STEP);

	// Next state: synchronisers, burst counter, access issue and output pipeline
	always_comb begin
		next_st = st;
		next_st.oe_s1 = output_drive_enable_n;
		next_st.oe_s2 = st.oe_s1;
		next_st.zz_s1 = sleep_request;
		next_st.zz_s2 = st.zz_s1;
		mem_we = 1'b0;
		mem_lanes = '0;
		mem_addr = {st.base[AW-1:BURST_W], burst_lo(st.mode_linear, st.base[BURST_W-1:0], st.beat)};
		acc_rd = 1'b0;
		acc_wr = 1'b0;
		if (st.zz_s2) begin
			next_st.active = 1'b0;
		end else if (deselect) begin
			next_st.active = 1'b0;
		end else if (start_proc) begin
			// Always a read; writes may only follow on later edges
			next_st.base = addr;
			next_st.beat = BURST_FIRST;
			next_st.active = 1'b1;
			mem_addr = addr;
			acc_rd = 1'b1;
		end else if (start_ctrl) begin
			next_st.base = addr;
			next_st.beat = BURST_FIRST;
			next_st.active = 1'b1;
			mem_addr = addr;
			acc_wr = wr_dec;
			acc_rd = ~wr_dec;
		end else if (cont_cycle) begin
			// Counter wraps inside the four-word block; the upper bits stay put
			next_st.beat = step_beat;
			mem_addr = {st.base[AW-1:BURST_W],
				burst_lo(st.mode_linear, st.base[BURST_W-1:0], step_beat)};
			acc_wr = wr_dec;
			acc_rd = ~wr_dec;
		end
		mem_we = acc_wr;
		mem_lanes = lanes;
		next_st.rd_stage = acc_rd;
		if (st.rd_stage) begin
			next_st.dq_out = mem_rdata;
		end
		// Enable is a synchronised copy, so it takes effect three edges late
		next_st.out_en_n = ~(st.rd_stage & ~acc_wr & ~st.oe_s2
			& ~st.zz_s2);
	end

	// State register; the strap is caught while reset is held
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= ST_RESET;
			st.mode_linear <= (burst_order_sel != ORDER_INTERLEAVED);
		end else begin
			st <= next_st;
		end
	end

	// Array; write data is taken on the same edge as the write decode
	sram_word_mem #(
		.AW(AW),
		.DW(DATA_W),
		.NL(LANES)
	) u_mem (
		.clk_sys(clk_sys),
		.wr_en(mem_we),
		.lane_en(mem_lanes),
		.addr(mem_addr),
		.wdata(dq_in),
		.rdata(mem_rdata)
	);

	assign dq_out = st.dq_out;
	assign dq_oe_n = st.out_en_n;
	assign sleep_active = st.zz_s2;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Checks
	AST_PROC_NO_WRITE: assert property (start_proc |-> !mem_we && mem_addr == addr)
		else $error("processor strobe cycle wrote or used wrong address");

	AST_GLOBAL_ALL: assert property (cont_cycle && !ctl.global_write_n
		|-> mem_we && mem_lanes == '1)
		else $error("global write did not write all lanes");

	AST_BYTE_MASK: assert property (mem_we && ctl.global_write_n
		|-> !ctl.byte_write_gate_n && mem_lanes == ~ctl.byte_lane_select_n)
		else $error("byte write lanes do not match selects");

	AST_WRITE_HIZ: assert property (acc_wr |=> dq_oe_n)
		else $error("data lines driven after a write cycle");

	AST_CTRL_WRITE: assert property (start_ctrl && wr_dec
		|-> mem_we && mem_addr == addr ##1 st.beat == BURST_FIRST)
		else $error("controller write not issued at external address");

	AST_ADV_STEP: assert property (cont_cycle && !ctl.burst_advance_n
		|=> st.beat == BURST_W'($past(st.beat) + BURST_STEP)
		&& $stable(st.base))
		else $error("burst counter did not step or base moved");

	AST_SUSPEND: assert property (cont_cycle && ctl.burst_advance_n
		|=> $stable(st.beat))
		else $error("suspend cycle moved the counter");

	AST_SLEEP_ENTRY: assert property (sleep_request [*2] |-> ##[0:1] sleep_active)
		else $error("sleep not entered within two cycles");

	AST_SLEEP_HIZ: assert property (sleep_active |=> dq_oe_n && !st.active)
		else $error("outputs driven or access kept during sleep");

	AST_DCD: assert property (deselect && !acc_wr ##1 !st.rd_stage |=> dq_oe_n)
		else $error("outputs not off one cycle after deselect");

	AST_READ_DRIVE: assert property (acc_rd && !st.zz_s2 ##1 !acc_wr && !st.oe_s2 && !st.zz_s2
		|=> !dq_oe_n)
		else $error("read data not driven after output register");

	// Burst order checks; the low bits follow the strap, the upper bits never move
	AST_LINEAR_ORDER: assert property (cont_cycle && st.mode_linear
		|-> mem_addr[BURST_W-1:0] == BURST_W'(st.base[BURST_W-1:0] + step_beat))
		else $error("linear burst address out of order");

	AST_INTERLEAVE_ORDER: assert property (cont_cycle && !st.mode_linear
		|-> mem_addr[BURST_W-1:0] == (st.base[BURST_W-1:0] ^ step_beat))
		else $error("interleaved burst address out of order");

	AST_UPPER_KEPT: assert property (cont_cycle
		|-> mem_addr[AW-1:BURST_W] == st.base[AW-1:BURST_W])
		else $error("burst moved the upper address bits");

	// Start, write decode and continue access checks
	AST_CTRL_READ: assert property (start_ctrl && !wr_dec
		|-> !mem_we && mem_addr == addr)
		else $error("controller read start wrote or used wrong address");

	AST_CTRL_NO_PROC: assert property (start_ctrl
		|-> ctl.proc_addr_strobe_n || ctl.pipelined_chip_select_n)
		else $error("controller start taken with processor strobe active");

	AST_WRITE_DECODE: assert property (wr_dec == (!ctl.global_write_n
		|| (!ctl.byte_write_gate_n && !(&ctl.byte_lane_select_n))))
		else $error("write decode does not match the write inputs");

	AST_CONT_ACCESS: assert property (cont_cycle
		|-> (mem_we == wr_dec) && (acc_rd == !wr_dec))
		else $error("continue cycle issued the wrong access kind");

	// Deselect, sleep and output pipeline checks
	AST_DESELECT_IDLE: assert property (deselect
		|-> !mem_we ##1 !st.active)
		else $error("deselect cycle wrote or kept the burst");

	AST_SLEEP_NO_WRITE: assert property (sleep_active |-> !mem_we)
		else $error("array written during sleep");

	AST_SLEEP_EXIT: assert property (!sleep_request [*2] |-> ##[0:1] !sleep_active)
		else $error("sleep not left within two cycles");

	AST_OE_MASK: assert property (acc_wr && !st.oe_s2 |=> dq_oe_n)
		else $error("drive enable not masked in a write cycle");

	AST_READ_REG: assert property (st.rd_stage |=> dq_out == $past(mem_rdata))
		else $error("output register did not take the array data");

	// Main scenarios
	COV_SUSPEND_WRITE: cover property (cont_cycle && wr_dec && ctl.burst_advance_n);
	COV_CTRL_WRITE: cover property (start_ctrl && wr_dec);
	COV_PROC_READ_DRIVE: cover property (start_proc ##2 !dq_oe_n);
	COV_BURST_WRAP: cover property (cont_cycle && !ctl.burst_advance_n && st.beat == BURST_LAST);
	COV_SLEEP: cover property ($rose(sleep_active));

endmodule

// ### verification/bus_ctl_model.sv
// Bus controller model that drives the burst memory's synchronous inputs
`timescale 1ns/1ps
module bus_ctl_model
	import sync_burst_sram_pkg::*;
#(
	parameter int AW = 6
) (
	// Clock
	input wire logic clk_sys,
	// Bus toward the memory
	output bus_ctl_t ctl,
	output logic [AW-1:0] addr,
	output logic [DATA_W-1:0] dq_in,
	output logic output_drive_enable_n,
	output logic sleep_request
);
	// Idle bus at start: strobes off, chip deselected
	initial begin
		ctl = '1;
		addr = '0;
		dq_in = '0;
		output_drive_enable_n = 1'h1;
		sleep_request = 1'h0;
	end
	// Drive enable change at the next clock
	task automatic oe(input logic v);
		@(posedge clk_sys);
		output_drive_enable_n <= v;
	endtask
	// One cycle; k: 0 proc start, 1 ctrl start, 2 advance, 3 suspend, 4 deselect, 5 idle
	task automatic cyc(input int k, input logic [AW-1:0] a, input logic [3:0] bw_n,
			input logic gw_n, input logic [31:0] d);
		bus_ctl_t c;
		logic wr;
		wr = !gw_n || !(&bw_n);
		if (wr && !output_drive_enable_n) begin
			oe(1'h1);
		end
		c = '1;
		c.depth_select_high = 1'h1;
		c.depth_select_low_n = 1'h0;
		c.pipelined_chip_select_n = k > 3;
		c.proc_addr_strobe_n = k != 0;
		c.ctrl_addr_strobe_n = k != 1 && k != 4;
		c.burst_advance_n = k != 2;
		c.global_write_n = gw_n;
		c.byte_write_gate_n = &bw_n;
		c.byte_lane_select_n = bw_n;
		@(posedge clk_sys);
		ctl <= c;
		addr <= a;
		// Released lines toggle, so stale data never passes for fresh
		dq_in <= wr ? d : ~dq_in;
	endtask
	// Sleep request, deselected before and idle during recovery
	task automatic zz(input logic v);
		if (v) begin
			cyc(4, '0, 4'hf, 1'h1, '0);
		end
		@(posedge clk_sys);
		sleep_request <= v;
		repeat (v ? 1 : 2) cyc(5, '0, 4'hf, 1'h1, '0);
	endtask
endmodule

// ### verification/sync_burst_sram_access_ctrl_test.sv
// Self-checking bench for the burst memory access control
`timescale 1ns/1ps
module sync_burst_sram_access_ctrl_test
	import sync_burst_sram_pkg::*;
;
	localparam int AW = 6;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic strap = ORDER_INTERLEAVED;
	bus_ctl_t ctl;
	logic [AW-1:0] addr;
	logic [31:0] dq_in;
	logic [31:0] dq_out;
	logic oe_n;
	logic sleep_request;
	logic dq_oe_n;
	logic sleep_active;
	logic [31:0] mem[64];
	int mismatches = 0;
	int checks_done = 0;

	// Design and controller model
	sync_burst_sram_access_ctrl #(.AW(AW)) DUT (
		.clk_sys(clk_sys), .rst(rst), .ctl(ctl), .addr(addr), .burst_order_sel(strap),
		.output_drive_enable_n(oe_n), .sleep_request(sleep_request), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .sleep_active(sleep_active));
	bus_ctl_model #(.AW(AW)) m (
		.clk_sys(clk_sys), .ctl(ctl), .addr(addr), .dq_in(dq_in),
		.output_drive_enable_n(oe_n), .sleep_request(sleep_request));

	// 25 MHz clock
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end

	// Word compare; flags reuse it zero-extended
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic flg(input logic got, input logic want);
		chk(32'(got), 32'(want));
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Reset for ten clocks; strap only counts while reset is high
	task automatic do_reset(input logic s);
		strap <= s;
		rst <= 1'h1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'h0;
		#1;
		flg(dq_oe_n, 1'h1);
		flg(sleep_active, 1'h0);
	endtask

	// Burst read from a; adv bit j-1 chooses advance or suspend; data lags two clocks
	task automatic rd(input logic [5:0] a, input int n, input logic [7:0] burst_advance);
		int bt[9];
		logic [1:0] lo;
		bt[0] = 0;
		m.cyc(0, a, 4'hf, 1'h1, '0);
		for (int j = 1; j <= n + 1; j++) begin
			bt[j] = bt[j-1] + burst_advance[j-1];
			m.cyc(burst_advance[j-1] ? 2 : 3, a, 4'hf, 1'h1, '0);
			#1;
			if (j >= 2) begin
				lo = strap ? a[1:0] ^ 2'(bt[j-2]) : 2'(a[1:0] + bt[j-2]);
				chk(dq_out, mem[{a[5:2], lo}]);
				flg(dq_oe_n, 1'h0);
			end
		end
	endtask

	task automatic t_write;
		for (int i = 0; i < 16; i++) begin
			mem[i] = 32'h01010101 * (i + 1);
			m.cyc(1, AW'(i), 4'hf, 1'h0, mem[i]);
		end
		$display("write test done");
	endtask

	// Suspend mid-burst, wrap past beat four, then double-cycle deselect
	task automatic t_burst;
		m.oe(1'h0);
		rd(6'h06, 6, 8'b1111_1011);
		m.cyc(4, '0, 4'hf, 1'h1, '0);
		@(posedge clk_sys);
		#1;
		flg(dq_oe_n, 1'h0);
		@(posedge clk_sys);
		#1;
		flg(dq_oe_n, 1'h1);
		$display("burst test done");
	endtask

	// Lane writes by either strobe; proc start ignores write inputs
	task automatic t_bytes;
		m.cyc(1, 6'h05, 4'ha, 1'h1, 32'haabbccdd);
		mem[5] = {mem[5][31:24], 8'hbb, mem[5][15:8], 8'hdd};
		m.cyc(0, 6'h09, 4'hf, 1'h0, 32'h12345678);
		m.cyc(3, 6'h00, 4'h7, 1'h1, 32'hfedcba98);
		mem[9][31:24] = 8'hfe;
		m.cyc(4, '0, 4'hf, 1'h1, '0);
		m.oe(1'h0);
		rd(6'h05, 1, 8'h00);
		rd(6'h09, 1, 8'h00);
		$display("byte test done");
	endtask

	// Sleep entry and exit within two clocks, contents kept
	task automatic t_sleep;
		m.zz(1'h1);
		@(posedge clk_sys);
		#1;
		flg(sleep_active, 1'h1);
		flg(dq_oe_n, 1'h1);
		m.zz(1'h0);
		#1;
		flg(sleep_active, 1'h0);
		rd(6'h05, 1, 8'h00);
		$display("sleep test done");
	endtask

	task automatic t_linear;
		do_reset(1'h0);
		rd(6'h01, 5, 8'hff);
		$display("linear test done");
	endtask

	// Main sequence
	initial begin
		do_reset(ORDER_INTERLEAVED);
		t_write();
		t_burst();
		t_bytes();
		t_sleep();
		t_linear();
		finish_test();
	end

	// Watchdog, well beyond the fewer than a hundred clocks the tests need
	initial begin
		repeat (3000) @(posedge clk_sys);
		mismatches++;
		finish_test();
	end
endmodule
